// [src/csb_carrier.sv]
module csb_carrier
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// duty in carrier cycles
	input wire logic [csb_pkg::CARRIER_W-1:0] duty,
	// high while the pin is to be pulled low
	output logic pull_low
);
	import csb_pkg::*;

	logic [CARRIER_W-1:0] cnt_reg;
	logic [CARRIER_W-1:0] cnt_next;
	logic pull_low_next;
	wire logic wrap = (cnt_reg == CARRIER_CYC - 10'h001);

	// free running carrier, no reset on duty change so the period never stretches
	assign cnt_next = wrap ? '0 : cnt_reg + 10'h001;
	assign pull_low_next = (cnt_next < duty);

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_reg <= '0;
			pull_low <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			pull_low <= pull_low_next;
		end
	end

	// the full 571-cycle period is too long for a plain delay, so wrap and range are checked apart
	carrier_wrap_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		wrap |=> (cnt_reg == '0))
		else $error("carrier does not restart after its last count");
	carrier_range_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		cnt_reg < CARRIER_CYC)
		else $error("carrier count beyond its period");
	duty_low_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(cnt_reg == 10'h000) && $stable(duty) |-> pull_low == (duty != '0))
		else $error("carrier output does not follow duty at period start");

endmodule : csb_carrier

// [src/csb_pkg.sv]
package csb_pkg;

	// clock and timing figures
	localparam longint CLK_HZ = 64'd20_000_000;
	localparam longint CARRIER_HZ = 64'd35_000;
	localparam longint BLINK_SLOW_HZ = 64'd1;
	localparam longint BLINK_FAST_HZ = 64'd4;
	localparam longint BAD_BATT_S = 64'd1800;
	localparam longint SAFETY_S = 64'd14400;

	// derived cycle counts
	localparam int CARRIER_W = 10;
	localparam logic [CARRIER_W-1:0] CARRIER_CYC = CARRIER_W'(CLK_HZ / CARRIER_HZ);
	localparam logic [CARRIER_W-1:0] DUTY_6_CYC = CARRIER_W'((CLK_HZ / CARRIER_HZ) * 6 / 100);
	localparam logic [CARRIER_W-1:0] DUTY_94_CYC = CARRIER_W'((CLK_HZ / CARRIER_HZ) * 94 / 100);
	localparam logic [CARRIER_W-1:0] DUTY_12_CYC = CARRIER_W'((CLK_HZ / CARRIER_HZ) * 12 / 100);
	localparam logic [CARRIER_W-1:0] DUTY_88_CYC = CARRIER_W'((CLK_HZ / CARRIER_HZ) * 88 / 100);
	localparam int BLINK_W = 32;
	localparam logic [BLINK_W-1:0] SLOW_HALF_CYC = BLINK_W'(CLK_HZ / (2 * BLINK_SLOW_HZ));
	localparam logic [BLINK_W-1:0] FAST_HALF_CYC = BLINK_W'(CLK_HZ / (2 * BLINK_FAST_HZ));
	localparam int TIMER_W = 40;
	localparam logic [TIMER_W-1:0] BAD_BATT_CYC = TIMER_W'(CLK_HZ * BAD_BATT_S);
	localparam logic [TIMER_W-1:0] SAFETY_CYC = TIMER_W'(CLK_HZ * SAFETY_S);

	// register map, word indices
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] REG_CTRL = 3'h0;
	localparam logic [ADDR_W-1:0] REG_STATE = 3'h1;
	localparam logic [ADDR_W-1:0] REG_EVT_STATUS = 3'h2;
	localparam logic [ADDR_W-1:0] REG_EVT_CLEAR = 3'h3;
	localparam logic [ADDR_W-1:0] REG_EVT_ENABLE = 3'h4;
	localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
	localparam logic [DATA_W-1:0] EVT_ENABLE_RESET = 8'h00;

	// ctrl bits
	localparam int CTRL_CHARGE_BIT = 0;
	localparam int CTRL_OTG_BIT = 1;

	// event bits
	localparam int EVT_W = 5;
	localparam int EVT_START_BIT = 0;
	localparam int EVT_DONE_BIT = 1;
	localparam int EVT_BAD_BIT = 2;
	localparam int EVT_TEMP_BIT = 3;
	localparam int EVT_OTG_BIT = 4;

	typedef enum logic [1:0] {
		CSB_IDLE = 2'b00,
		CSB_CHARGE = 2'b01,
		CSB_DONE = 2'b10,
		CSB_BAD = 2'b11
	} csb_state_t;

	typedef enum logic [1:0] {
		PAT_OFF = 2'b00,
		PAT_ON = 2'b01,
		PAT_TEMP = 2'b10,
		PAT_FAULT = 2'b11
	} csb_pat_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} csb_bus_req_t;

	typedef struct packed {
		logic battery_below_trickle;
		logic float_reached;
		logic current_below_c10;
		logic input_current_limit;
		logic too_hot;
		logic too_cold;
		logic thermistor_grounded;
		logic otg_short;
		logic recharge_request;
	} csb_sense_t;

endpackage : csb_pkg

// [src/csb_status.sv]
// Function
// - hold the status pin low throughout a normal charge cycle
// - release the pin once float voltage and one-tenth current are reached
// - faults toggle the pin at 35kHz with duty alternating slowly
// - temperature fault alternates 6% and 94% duty at 1Hz, half each
// - bad battery alternates 12% and 88% duty at 4Hz, half each
// - bad battery when below trickle threshold continuously for half an hour
// - bad battery timeout ends the charge cycle and shows the fault
// - ignore the one-tenth current indication while input is current limited
// - on-the-go bus short shows the same 4Hz 12%/88% pattern
// - too hot or too cold pauses charging and freezes the float safety timer
// - grounded thermistor sense disables all temperature qualification
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
module csb_status #(
	parameter logic [csb_pkg::BLINK_W-1:0] SLOW_HALF = csb_pkg::SLOW_HALF_CYC,
	parameter logic [csb_pkg::BLINK_W-1:0] FAST_HALF = csb_pkg::FAST_HALF_CYC,
	parameter logic [csb_pkg::TIMER_W-1:0] BAD_BATT = csb_pkg::BAD_BATT_CYC,
	parameter logic [csb_pkg::TIMER_W-1:0] SAFETY = csb_pkg::SAFETY_CYC
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// register port
	input wire csb_pkg::csb_bus_req_t bus,
	output logic [csb_pkg::DATA_W-1:0] rdata,
	output logic irq,
	// charger qualifiers
	input wire csb_pkg::csb_sense_t sense,
	output logic charge_enable,
	output logic safety_timer_run,
	// open-drain status pin
	input wire logic charge_status_n_i,
	output logic charge_status_n_o,
	output logic charge_status_n_oe_n
);
	import csb_pkg::*;

	function automatic logic [CARRIER_W-1:0] duty_of(input csb_pat_t pat, input logic hi);
		logic [CARRIER_W-1:0] d;
		d = '0;
		unique case (pat)
			PAT_OFF: d = '0;
			PAT_ON: d = CARRIER_CYC;
			PAT_TEMP: d = hi ? DUTY_94_CYC : DUTY_6_CYC;
			PAT_FAULT: d = hi ? DUTY_88_CYC : DUTY_12_CYC;
		endcase
		return d;
	endfunction : duty_of

	// registers
	csb_state_t state_reg;
	csb_state_t state_next;
	csb_pat_t pat_reg;
	csb_pat_t pat_next;
	logic [DATA_W-1:0] ctrl_reg;
	logic [DATA_W-1:0] ctrl_next;
	logic [EVT_W-1:0] evt_reg;
	logic [EVT_W-1:0] evt_next;
	logic [EVT_W-1:0] evt_en_reg;
	logic [EVT_W-1:0] evt_en_next;
	logic charge_en_d_reg;
	logic otg_fault_d_reg;
	logic [TIMER_W-1:0] bad_cnt_reg;
	logic [TIMER_W-1:0] bad_cnt_next;
	logic [TIMER_W-1:0] safety_cnt_reg;
	logic [TIMER_W-1:0] safety_cnt_next;
	logic [BLINK_W-1:0] blink_cnt_reg;
	logic [BLINK_W-1:0] blink_cnt_next;
	logic blink_hi_reg;
	logic blink_hi_next;
	logic oe_n_next;
	logic [DATA_W-1:0] rdata_next;
	logic pwm_low;

	// qualifiers
	wire logic charge_on = ctrl_reg[CTRL_CHARGE_BIT];
	wire logic otg_on = ctrl_reg[CTRL_OTG_BIT];
	wire logic temp_fault = (sense.too_hot | sense.too_cold) & ~sense.thermistor_grounded;
	wire logic charging = (state_reg == CSB_CHARGE);
	wire logic otg_fault = otg_on & sense.otg_short;
	wire logic c10_done = sense.float_reached & sense.current_below_c10
		& ~sense.input_current_limit;
	wire logic start_evt = charge_on & ~charge_en_d_reg
		| charge_on & sense.recharge_request & (state_reg == CSB_DONE);
	wire logic bad_run = charging & sense.battery_below_trickle & ~temp_fault;
	wire logic bad_expire = bad_run & (bad_cnt_reg == BAD_BATT - 40'h1);
	// the safety timer only runs in float and stands still while temperature is bad
	wire logic safety_run = charging & sense.float_reached & ~temp_fault;
	wire logic safety_expire = safety_run & (safety_cnt_reg == SAFETY - 40'h1);

	// charge state
	always_comb
	begin
		state_next = state_reg;
		if (!charge_on)
			state_next = CSB_IDLE;
		else if (start_evt)
			state_next = CSB_CHARGE;
		else if (bad_expire)
			state_next = CSB_BAD;
		else if (safety_expire)
			state_next = CSB_DONE;
	end

	// bad battery timer restarts whenever the battery climbs over the threshold
	assign bad_cnt_next = (start_evt | ~charging | ~sense.battery_below_trickle) ? '0 :
		bad_run ? bad_cnt_reg + 40'h1 : bad_cnt_reg;
	assign safety_cnt_next = (start_evt | ~charging) ? '0 :
		safety_run ? safety_cnt_reg + 40'h1 : safety_cnt_reg;

	// pin pattern, fast faults take priority so a bad battery is never hidden
	always_comb
	begin
		if (state_reg == CSB_BAD || otg_fault)
			pat_next = PAT_FAULT;
		else if (charging && temp_fault)
			pat_next = PAT_TEMP;
		else if (charging && !c10_done)
			pat_next = PAT_ON;
		else
			pat_next = PAT_OFF;
	end

	// blink counter restarts on a pattern change so each half is whole
	wire logic [BLINK_W-1:0] half_cyc = (pat_reg == PAT_TEMP) ? SLOW_HALF : FAST_HALF;
	wire logic blink_wrap = (blink_cnt_reg == half_cyc - 32'h1);
	assign blink_cnt_next = (pat_next != pat_reg || blink_wrap) ? '0 :
		blink_cnt_reg + 32'h1;
	assign blink_hi_next = (pat_next != pat_reg) ? 1'b0 :
		blink_wrap ? ~blink_hi_reg : blink_hi_reg;

	csb_carrier u_carrier (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.duty(duty_of(pat_reg, blink_hi_reg)),
		.pull_low(pwm_low)
	);

	// steady patterns bypass the carrier so charging is a clean 100%
	assign oe_n_next = (pat_reg == PAT_ON) ? 1'b0 :
		(pat_reg == PAT_OFF) ? 1'b1 : ~pwm_low;

	// register bus
	wire logic wr_ctrl = bus.wr && bus.addr == REG_CTRL;
	wire logic wr_clear = bus.wr && bus.addr == REG_EVT_CLEAR;
	wire logic wr_enable = bus.wr && bus.addr == REG_EVT_ENABLE;
	wire logic [EVT_W-1:0] evt_set = {
		otg_fault & ~otg_fault_d_reg,
		(pat_next == PAT_TEMP) & (pat_reg != PAT_TEMP),
		bad_expire,
		(pat_reg == PAT_ON) & (pat_next == PAT_OFF),
		start_evt
	};
	assign ctrl_next = wr_ctrl ? bus.wdata : ctrl_reg;
	assign evt_en_next = wr_enable ? bus.wdata[EVT_W-1:0] : evt_en_reg;
	// a new event wins over a clear in the same cycle
	assign evt_next = (evt_reg & ~(wr_clear ? bus.wdata[EVT_W-1:0] : '0)) | evt_set;
	wire logic [DATA_W-1:0] state_view = {1'b0, charge_enable, charge_status_n_i,
		blink_hi_reg, pat_reg, state_reg};
	always_comb
	begin
		rdata_next = '0;
		if (bus.rd)
		begin
			unique case (bus.addr)
				REG_CTRL: rdata_next = ctrl_reg;
				REG_STATE: rdata_next = state_view;
				REG_EVT_STATUS: rdata_next = DATA_W'(evt_reg);
				REG_EVT_ENABLE: rdata_next = DATA_W'(evt_en_reg);
				default: rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg <= CSB_IDLE;
			pat_reg <= PAT_OFF;
			ctrl_reg <= CTRL_RESET;
			evt_reg <= '0;
			evt_en_reg <= EVT_W'(EVT_ENABLE_RESET);
			charge_en_d_reg <= 1'b0;
			otg_fault_d_reg <= 1'b0;
			bad_cnt_reg <= '0;
			safety_cnt_reg <= '0;
			blink_cnt_reg <= '0;
			blink_hi_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			pat_reg <= pat_next;
			ctrl_reg <= ctrl_next;
			evt_reg <= evt_next;
			evt_en_reg <= evt_en_next;
			charge_en_d_reg <= charge_on;
			// a short that starts while a bad battery already blinks must still raise its event
			otg_fault_d_reg <= otg_fault;
			bad_cnt_reg <= bad_cnt_next;
			safety_cnt_reg <= safety_cnt_next;
			blink_cnt_reg <= blink_cnt_next;
			blink_hi_reg <= blink_hi_next;
		end
	end

	// output flops
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rdata <= '0;
			irq <= 1'b0;
			charge_enable <= 1'b0;
			safety_timer_run <= 1'b0;
			charge_status_n_o <= 1'b0;
			charge_status_n_oe_n <= 1'b1;
		end
		else
		begin
			rdata <= rdata_next;
			irq <= |(evt_next & evt_en_next);
			charge_enable <= (state_next == CSB_CHARGE) & ~temp_fault;
			safety_timer_run <= safety_run;
			charge_status_n_o <= 1'b0;
			charge_status_n_oe_n <= oe_n_next;
		end
	end

	// checks
	charge_low_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		pat_reg == PAT_ON |=> !charge_status_n_oe_n)
		else $error("pin not held low while charging");
	release_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		charging && c10_done && !temp_fault && !otg_fault |=> pat_reg == PAT_OFF ##1
		charge_status_n_oe_n)
		else $error("pin not released at end of charge");
	temp_duty_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		pat_reg == PAT_TEMP |-> duty_of(pat_reg, blink_hi_reg) ==
		(blink_hi_reg ? 10'd536 : 10'd34))
		else $error("temperature duty wrong");
	fault_duty_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		pat_reg == PAT_FAULT |-> duty_of(pat_reg, blink_hi_reg) ==
		(blink_hi_reg ? 10'd502 : 10'd68))
		else $error("bad battery duty wrong");
	bad_timeout_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		bad_run && charge_on && !start_evt && bad_cnt_reg == BAD_BATT - 40'h1
		|=> state_reg == CSB_BAD)
		else $error("bad battery not declared at timeout");
	bad_ends_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		$rose(state_reg == CSB_BAD) |-> !charge_enable ##1 pat_reg == PAT_FAULT)
		else $error("bad battery did not end charging");
	c10_mask_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		charging && sense.input_current_limit && !temp_fault && !otg_fault
		|=> pat_reg == PAT_ON)
		else $error("end of charge shown during current limit");
	otg_short_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		otg_on && sense.otg_short |=> pat_reg == PAT_FAULT)
		else $error("bus short not shown");
	safety_freeze_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		charging && temp_fault && state_next == CSB_CHARGE && !start_evt
		|=> safety_cnt_reg == $past(safety_cnt_reg) && !charge_enable)
		else $error("charging or safety timer not paused");
	ntc_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		sense.thermistor_grounded && charging && !otg_fault && !sense.input_current_limit
		&& !sense.float_reached |=> pat_reg == PAT_ON)
		else $error("temperature acted with sense grounded");
	blink_half_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		blink_wrap && pat_next == pat_reg |=> blink_hi_reg != $past(blink_hi_reg)
		&& blink_cnt_reg == '0)
		else $error("blink half period wrong");

	temp_seen_c: cover property (@(posedge ref_clk) disable iff (!nrst)
		pat_reg == PAT_TEMP ##1 blink_hi_reg);
	bad_seen_c: cover property (@(posedge ref_clk) disable iff (!nrst)
		state_reg == CSB_BAD);
	done_seen_c: cover property (@(posedge ref_clk) disable iff (!nrst)
		pat_reg == PAT_ON ##1 pat_reg == PAT_OFF);
	irq_seen_c: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(irq));

endmodule : csb_status

// [tb/csb_led_model.sv]
module csb_led_model
(
	// clock and reset
	ref_clk,
	nrst,
	// status pin from the block
	pin_o,
	pin_oe_n,
	// resolved pin and pulse readings
	pin,
	low_len,
	low_done,
	reading_ok
);
	timeunit 1ns;
	timeprecision 1ns;
	input wire logic ref_clk;
	input wire logic nrst;
	input wire logic pin_o;
	input wire logic pin_oe_n;
	output logic pin;
	output logic [15:0] low_len;
	output logic low_done;
	output logic reading_ok;
	logic [15:0] lo_cnt;
	logic [15:0] hi_cnt;
	logic [15:0] hi_len;
	// pull-up resistor: a released pin reads high
	assign pin = pin_oe_n ? 1'b1 : pin_o;
	// a reading whose low run equals the high run before it comes out exactly 50% and is thrown away
	assign reading_ok = low_len != hi_len;
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			lo_cnt <= 16'h0;
			hi_cnt <= 16'h0;
			hi_len <= 16'h0;
			low_len <= 16'h0;
			low_done <= 1'b0;
		end
		else if (!pin)
		begin
			lo_cnt <= lo_cnt + 16'h1;
			hi_cnt <= 16'h0;
			low_done <= 1'b0;
			if (hi_cnt != 16'h0)
				hi_len <= hi_cnt;
		end
		else
		begin
			hi_cnt <= hi_cnt + 16'h1;
			lo_cnt <= 16'h0;
			low_done <= lo_cnt != 16'h0;
			if (lo_cnt != 16'h0)
				low_len <= lo_cnt;
		end
	end
endmodule : csb_led_model

// [tb/csb_status_bench.sv]
module csb_status_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import csb_pkg::*;
	// short blink halves still hold a few whole 571-cycle carrier periods
	localparam logic [31:0] SH = 32'h7D0;
	localparam logic [31:0] FH = 32'h5DC;
	localparam logic [39:0] BB = 40'h28;
	localparam logic [39:0] SF = 40'h3C;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	csb_bus_req_t bus = '0;
	csb_sense_t sense = '0;
	logic [7:0] rdata;
	logic [7:0] d;
	logic irq;
	logic charge_enable;
	logic safety_timer_run;
	logic pin_o;
	logic pin_oe_n;
	logic pin;
	logic low_done;
	logic reading_ok;
	logic [15:0] low_len;
	int err_total = 0;
	int cmp_count = 0;
	always #25 ref_clk = ~ref_clk;
	csb_status #(.SLOW_HALF(SH), .FAST_HALF(FH), .BAD_BATT(BB), .SAFETY(SF)) u_dut (
		.ref_clk(ref_clk), .nrst(nrst), .bus(bus), .rdata(rdata), .irq(irq), .sense(sense),
		.charge_enable(charge_enable), .safety_timer_run(safety_timer_run),
		.charge_status_n_i(pin), .charge_status_n_o(pin_o), .charge_status_n_oe_n(pin_oe_n));
	csb_led_model u_led (.ref_clk(ref_clk), .nrst(nrst), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
		.pin(pin), .low_len(low_len), .low_done(low_done), .reading_ok(reading_ok));
	task stop_test;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	// strobes drop a whole cycle before the next access, so no signal is set twice per step
	task wr(input logic [2:0] a, input logic [7:0] v);
		if (ref_clk !== 1'b1)
			@(posedge ref_clk);
		bus.wr <= 1'b1;
		bus.addr <= a;
		bus.wdata <= v;
		@(posedge ref_clk);
		bus.wr <= 1'b0;
		@(posedge ref_clk);
	endtask : wr
	task rd(input logic [2:0] a);
		if (ref_clk !== 1'b1)
			@(posedge ref_clk);
		bus.rd <= 1'b1;
		bus.addr <= a;
		@(posedge ref_clk);
		bus.rd <= 1'b0;
		@(negedge ref_clk);
		d = rdata;
		@(posedge ref_clk);
	endtask : rd
	task held(input int n);
		int k;
		k = 0;
		repeat (n)
		begin
			@(negedge ref_clk);
			if (pin !== 1'b0)
				k++;
		end
		chk(16'(k), 16'h0);
		@(posedge ref_clk);
	endtask : held
	task watch(input logic [15:0] lo, input logic [15:0] hi, input int n);
		logic sa;
		logic sb;
		sa = 1'b0;
		sb = 1'b0;
		repeat (n)
		begin
			@(negedge ref_clk);
			if (low_done === 1'b1 && reading_ok === 1'b1 && low_len === lo)
				sa = 1'b1;
			if (low_done === 1'b1 && reading_ok === 1'b1 && low_len === hi)
				sb = 1'b1;
		end
		chk(16'(sa), 16'h1);
		chk(16'(sb), 16'h1);
		@(posedge ref_clk);
	endtask : watch
	initial
	begin
		repeat (60000) @(posedge ref_clk);
		err_total++;
		$display("FAIL t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		stop_test();
	end
	initial
	begin
		cyc(6);
		nrst <= 1'b1;
		cyc(1);
		chk(16'(pin), 16'h1);
		rd(REG_CTRL);
		chk(16'(d), 16'(CTRL_RESET));
		rd(REG_EVT_ENABLE);
		chk(16'(d), 16'(EVT_ENABLE_RESET));
		rd(3'h5);
		chk(16'(d), 16'h0);
		rd(REG_EVT_CLEAR);
		chk(16'(d), 16'h0);
		$display("test reset done");
		wr(REG_EVT_ENABLE, 8'h01);
		wr(REG_CTRL, 8'h01);
		cyc(2);
		held(1000);
		chk(16'(irq), 16'h1);
		chk(16'(charge_enable), 16'h1);
		wr(REG_EVT_CLEAR, 8'h01);
		cyc(1);
		@(negedge ref_clk);
		chk(16'(irq), 16'h0);
		rd(REG_STATE);
		chk(16'(d[3:0]), 16'({PAT_ON, CSB_CHARGE}));
		$display("test charge done");
		sense.float_reached <= 1'b1;
		sense.current_below_c10 <= 1'b1;
		sense.input_current_limit <= 1'b1;
		held(20);
		chk(16'(safety_timer_run), 16'h1);
		sense.input_current_limit <= 1'b0;
		cyc(3);
		@(negedge ref_clk);
		chk(16'(pin), 16'h1);
		rd(REG_EVT_STATUS);
		chk(16'(d[EVT_DONE_BIT]), 16'h1);
		$display("test end of charge done");
		sense.float_reached <= 1'b0;
		sense.current_below_c10 <= 1'b0;
		wr(REG_CTRL, 8'h00);
		wr(REG_CTRL, 8'h01);
		for (int i = 0; i < 2; i++)
		begin
			sense.too_hot <= i == 0;
			sense.too_cold <= i == 1;
			cyc(3);
			@(negedge ref_clk);
			chk(16'(charge_enable), 16'h0);
		end
		watch(16'(DUTY_6_CYC), 16'(DUTY_94_CYC), 2 * SH + 1200);
		sense.float_reached <= 1'b1;
		cyc(3);
		@(negedge ref_clk);
		chk(16'(safety_timer_run), 16'h0);
		sense.float_reached <= 1'b0;
		sense.thermistor_grounded <= 1'b1;
		cyc(4);
		held(600);
		chk(16'(charge_enable), 16'h1);
		$display("test temperature done");
		sense.too_cold <= 1'b0;
		sense.thermistor_grounded <= 1'b0;
		sense.battery_below_trickle <= 1'b1;
		wr(REG_CTRL, 8'h00);
		wr(REG_CTRL, 8'h01);
		cyc(2);
		held(int'(BB) - 8);
		cyc(20);
		@(negedge ref_clk);
		chk(16'(charge_enable), 16'h0);
		rd(REG_STATE);
		chk(16'(d[1:0]), 16'(CSB_BAD));
		watch(16'(DUTY_12_CYC), 16'(DUTY_88_CYC), 2 * FH + 1200);
		$display("test bad battery done");
		wr(REG_CTRL, 8'h02);
		sense.battery_below_trickle <= 1'b0;
		sense.otg_short <= 1'b1;
		cyc(3);
		watch(16'(DUTY_12_CYC), 16'(DUTY_88_CYC), 2 * FH + 1200);
		rd(REG_EVT_STATUS);
		chk(16'(d[EVT_OTG_BIT]), 16'h1);
		$display("test bus short done");
		stop_test();
	end
endmodule : csb_status_bench
